// >>> ccs_defines.svh
// Register map, field positions, codes and timing for the CAN control block
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// Byte offsets on the Wishbone bus
`define CCS_ADDR_MODE       8'h00
`define CCS_ADDR_DCOUNT     8'h04
`define CCS_ADDR_VECTOR     8'h08
`define CCS_ADDR_FIFOCFG    8'h0C
`define CCS_ADDR_FIFOPTR    8'h10
`define CCS_ADDR_FLAGS      8'h14

// Mode control fields
`define CCS_MC_IDLE_STOP    13
`define CCS_MC_ABORT        12
`define CCS_MC_REQ          10:8
`define CCS_MC_CUR          7:5
`define CCS_MC_CAPTURE      3
`define CCS_MC_WINDOW       0

// Mode codes
`define CCS_MODE_NORMAL     3'h0
`define CCS_MODE_DISABLE    3'h1
`define CCS_MODE_LOOPBACK   3'h2
`define CCS_MODE_LISTEN     3'h3
`define CCS_MODE_CONFIG     3'h4
`define CCS_MODE_RSVD_A     3'h5
`define CCS_MODE_RSVD_B     3'h6
`define CCS_MODE_LISTEN_ALL 3'h7

// Other fields
`define CCS_VEC_HIT         12:8
`define CCS_VEC_CODE        6:0
`define CCS_FC_DMA          15:13
`define CCS_FC_START        4:0
`define CCS_FP_WRITE        13:8
`define CCS_FP_READ         5:0
`define CCS_IF_STATUS       13:8
`define CCS_IF_FLAGS        7:0
`define CCS_DCOUNT_MAX      5'h11
`define CCS_DMA_RSVD        3'h7

// Flag bit positions
`define CCS_F_INVALID       7
`define CCS_F_WAKE          6
`define CCS_F_ERROR         5
`define CCS_F_FIFO          3
`define CCS_F_OVERFLOW      2
`define CCS_F_RXBUF         1
`define CCS_F_TXBUF         0
`define CCS_FLAG_MASK       8'hEF

// Interrupt codes
`define CCS_IC_NONE         7'h40
`define CCS_IC_ERROR        7'h41
`define CCS_IC_WAKE         7'h42
`define CCS_IC_OVERFLOW     7'h43
`define CCS_IC_FIFO         7'h44

// Bus idle detection
`define CCS_IDLE_BITS       11
`define CCS_IDLE_CNT_W      4

`endif

// >>> ccs_pkg.sv
// State types for the CAN control and status block
package ccs_pkg;

	typedef struct packed {
		logic        sync1;
		logic        sync2;
		logic [3:0]  count;
		logic        idle;
	} ccs_idle_state_t;

	typedef struct packed {
		logic [6:0]  code;
	} ccs_irq_state_t;

	typedef struct packed {
		logic        idleStop;
		logic        abortAll;
		logic [2:0]  reqMode;
		logic [2:0]  curMode;
		logic        rxCapEn;
		logic        mapWin;
		logic [4:0]  dnCount;
		logic [4:0]  hitFilter;
		logic [2:0]  dma_buffer_count;
		logic [4:0]  fifoStart;
		logic [5:0]  wrPtr;
		logic [5:0]  rdPtr;
		logic [5:0]  statusPrev;
		logic [7:0]  flags;
		logic        ack;
		logic [31:0] datOut;
		logic        capture;
		logic        asmCopy;
	} ccs_main_state_t;

endpackage

// >>> ccs_idle_detect.sv
// Receive pin synchroniser and bus idle detector
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"

module ccs_idle_detect
#(
	parameter int IDLE_BITS = `CCS_IDLE_BITS
)
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic rxPin,
	input  wire logic bitTick,
	output logic      rxSync,
	output logic      busIdle
);
	import ccs_pkg::*;

	ccs_idle_state_t state;
	ccs_idle_state_t next_state;

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		next_state.sync1 = rxPin;
		next_state.sync2 = state.sync1;
		// Count recessive bits, restart on any dominant bit
		if (bitTick)
		begin
			if (!state.sync2)
				next_state.count = '0;
			else if (state.count < IDLE_BITS[`CCS_IDLE_CNT_W-1:0])
				next_state.count = state.count + 4'h1;
		end
		next_state.idle = (state.count >= IDLE_BITS[`CCS_IDLE_CNT_W-1:0])
			&& state.sync2;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state <= '{sync1: 1'b1, sync2: 1'b1, count: '0, idle: 1'b0};
		else
			state <= next_state;
	end

	assign rxSync = state.sync2;
	assign busIdle = state.idle;
endmodule
`default_nettype wire

// >>> ccs_irq_code.sv
// Interrupt code priority encoder
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"

module ccs_irq_code
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	input  wire logic [7:0]  flags,
	input  wire logic [15:0] bufferPending,
	output logic      [6:0]  interruptCode
);
	import ccs_pkg::*;

	ccs_irq_state_t state;
	ccs_irq_state_t next_state;

	// Lowest pending buffer number wins
	function automatic logic [6:0] lowestBuffer(input logic [15:0] pend);
		logic [6:0] code;
		code = `CCS_IC_NONE;
		for (int i = 15; i >= 0; i--)
			if (pend[i])
				code = 7'(i);
		return code;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		next_state = state;
		if (flags[`CCS_F_ERROR])
			next_state.code = `CCS_IC_ERROR;
		else if (flags[`CCS_F_OVERFLOW])
			next_state.code = `CCS_IC_OVERFLOW;
		else if (flags[`CCS_F_WAKE])
			next_state.code = `CCS_IC_WAKE;
		else if (flags[`CCS_F_FIFO])
			next_state.code = `CCS_IC_FIFO;
		else if (flags[`CCS_F_TXBUF] || flags[`CCS_F_RXBUF])
			next_state.code = lowestBuffer(bufferPending);
		else
			next_state.code = `CCS_IC_NONE;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state <= '{code: `CCS_IC_NONE};
		else
			state <= next_state;
	end

	assign interruptCode = state.code;
endmodule
`default_nettype wire

// >>> ccs_top.sv
// CAN controller mode, FIFO and status control with a Wishbone slave
//
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"

module ccs_top
#(
	parameter int IDLE_BITS = `CCS_IDLE_BITS
)
(
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// CAN pins
	input  wire logic        canRxPin,
	output logic             canTxPin,
	output logic             canTxOe_n,
	output logic             pinsReleased,
	// Protocol engine side
	input  wire logic        bitTick,
	input  wire logic        coreTx,
	output logic             coreRx,
	input  wire logic        protoError,
	input  wire logic        rxMsgDone,
	input  wire logic [3:0]  rxFilterHit,
	input  wire logic        allTxAborted,
	input  wire logic [4:0]  dataCompareIn,
	output logic             listenAll,
	output logic             asmCopy,
	output logic             abortAllTx,
	output logic             rxCapture,
	output logic             mapWindowSelect,
	output logic      [4:0]  dataCompareBits,
	output logic      [2:0]  currentMode,
	output logic      [5:0]  dmaBufferTotal,
	// Power
	input  wire logic        chipIdle,
	output logic             moduleHalt,
	// Error state and events
	input  wire logic        txBusOff,
	input  wire logic        txPassive,
	input  wire logic        rxPassive,
	input  wire logic        txWarning,
	input  wire logic        rxWarning,
	input  wire logic        invalidMsgEvt,
	input  wire logic        wakeEvt,
	input  wire logic        fifoAlmostFullEvt,
	input  wire logic        rxOverflowEvt,
	input  wire logic        rxBufferEvt,
	input  wire logic        txBufferEvt,
	input  wire logic [15:0] bufferPending,
	input  wire logic        fifoWrite,
	input  wire logic        fifoRead
);
	import ccs_pkg::*;

	ccs_main_state_t state;
	ccs_main_state_t next_state;

	logic        rxSync;
	logic        busIdle;
	logic [6:0]  interruptCode;
	logic [5:0]  statusNow;
	logic        busReq;
	logic        busWrite;
	logic [15:0] wmask;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic        txDriven;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Byte enables to a 16-bit write mask
	function automatic logic [15:0] laneMask(input logic [3:0] sel);
		return {{8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// Buffers held in DMA memory for a size code
	function automatic logic [5:0] dmaCount(input logic [2:0] code);
		case (code)
			3'h0:    return 6'h04;
			3'h1:    return 6'h06;
			3'h2:    return 6'h08;
			3'h3:    return 6'h0C;
			3'h4:    return 6'h10;
			3'h5:    return 6'h18;
			3'h6:    return 6'h20;
			default: return 6'h20;
		endcase
	endfunction

	// FIFO pointer step, wrapping back to the start buffer
	function automatic logic [5:0] nextPtr(input logic [5:0] ptr,
		input logic [4:0] start, input logic [2:0] code);
		logic [5:0] inc;
		inc = ptr + 6'h01;
		if (inc >= dmaCount(code))
			return {1'b0, start};
		return inc;
	endfunction

	// Codes that request a real mode
	function automatic logic validMode(input logic [2:0] code);
		return code != `CCS_MODE_RSVD_A && code != `CCS_MODE_RSVD_B;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Submodules

	ccs_idle_detect
	#(
		.IDLE_BITS (IDLE_BITS)
	)
	u_idle
	(
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.rxPin   (canRxPin),
		.bitTick (bitTick),
		.rxSync  (rxSync),
		.busIdle (busIdle)
	);

	ccs_irq_code u_irq
	(
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.flags         (state.flags),
		.bufferPending (bufferPending),
		.interruptCode (interruptCode)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus decode

	assign statusNow = {txBusOff, txPassive, rxPassive, txWarning, rxWarning,
		txWarning | rxWarning};
	assign busReq   = wb_cyc_i && wb_stb_i;
	assign busWrite = busReq && wb_we_i && state.ack;
	assign wmask    = laneMask(wb_sel_i);
	assign wdata    = wb_dat_i[15:0];

	always_comb
	begin
		rdata = 16'h0000;
		case (wb_adr_i)
			`CCS_ADDR_MODE:
			begin
				rdata[`CCS_MC_IDLE_STOP] = state.idleStop;
				rdata[`CCS_MC_ABORT]     = state.abortAll;
				rdata[`CCS_MC_REQ]       = state.reqMode;
				rdata[`CCS_MC_CUR]       = state.curMode;
				rdata[`CCS_MC_CAPTURE]   = state.rxCapEn;
				rdata[`CCS_MC_WINDOW]    = state.mapWin;
			end
			`CCS_ADDR_DCOUNT:
				rdata[4:0] = state.dnCount;
			`CCS_ADDR_VECTOR:
			begin
				rdata[`CCS_VEC_HIT]  = state.hitFilter;
				rdata[`CCS_VEC_CODE] = interruptCode;
			end
			`CCS_ADDR_FIFOCFG:
			begin
				rdata[`CCS_FC_DMA]   = state.dma_buffer_count;
				rdata[`CCS_FC_START] = state.fifoStart;
			end
			`CCS_ADDR_FIFOPTR:
			begin
				rdata[`CCS_FP_WRITE] = state.wrPtr;
				rdata[`CCS_FP_READ]  = state.rdPtr;
			end
			`CCS_ADDR_FLAGS:
			begin
				rdata[`CCS_IF_STATUS] = statusNow;
				rdata[`CCS_IF_FLAGS]  = state.flags;
			end
			default:
				rdata = 16'h0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		next_state = state;

		// Classic Wishbone: answer one cycle after the request, drop after
		next_state.ack = busReq && !state.ack;
		if (busReq && !state.ack)
			next_state.datOut = {16'h0000, rdata};

		// Mode control writes
		if (busWrite && wb_adr_i == `CCS_ADDR_MODE)
		begin
			if (wmask[`CCS_MC_IDLE_STOP])
				next_state.idleStop = wdata[`CCS_MC_IDLE_STOP];
			if (wmask[8] && validMode(wdata[`CCS_MC_REQ]))
				next_state.reqMode = wdata[`CCS_MC_REQ];
			if (wmask[`CCS_MC_CAPTURE])
				next_state.rxCapEn = wdata[`CCS_MC_CAPTURE];
			if (wmask[`CCS_MC_WINDOW])
				next_state.mapWin = wdata[`CCS_MC_WINDOW];
		end

		// Abort-all: done clears it, a fresh software set wins
		if (allTxAborted)
			next_state.abortAll = 1'b0;
		if (busWrite && wb_adr_i == `CCS_ADDR_MODE
			&& wmask[`CCS_MC_ABORT] && wdata[`CCS_MC_ABORT])
			next_state.abortAll = 1'b1;

		// Mode takes effect only on an idle bus
		if (busIdle && state.curMode != state.reqMode)
			next_state.curMode = state.reqMode;

		// Compare count from the filter side; invalid reads as none
		next_state.dnCount = dataCompareIn;
		if (dataCompareIn > `CCS_DCOUNT_MAX)
			next_state.dnCount = 5'h00;

		// FIFO configuration; reserved size code is refused
		if (busWrite && wb_adr_i == `CCS_ADDR_FIFOCFG)
		begin
			if (wmask[15] && wdata[`CCS_FC_DMA] != `CCS_DMA_RSVD)
				next_state.dma_buffer_count = wdata[`CCS_FC_DMA];
			if (wmask[0])
			begin
				next_state.fifoStart = wdata[`CCS_FC_START];
				next_state.wrPtr = {1'b0, wdata[`CCS_FC_START]};
				next_state.rdPtr = {1'b0, wdata[`CCS_FC_START]};
			end
		end
		else
		begin
			if (fifoWrite)
				next_state.wrPtr = nextPtr(state.wrPtr, state.fifoStart,
					state.dma_buffer_count);
			if (fifoRead)
				next_state.rdPtr = nextPtr(state.rdPtr, state.fifoStart,
					state.dma_buffer_count);
		end

		// Hit filter captured with each received message
		if (rxMsgDone)
			next_state.hitFilter = {1'b0, rxFilterHit};

		// Pulses toward the protocol engine and capture timer
		next_state.capture = rxMsgDone && state.rxCapEn;
		next_state.asmCopy = protoError
			&& state.curMode == `CCS_MODE_LISTEN_ALL;

		// Flags: software writes zero to clear, hardware set wins
		next_state.statusPrev = statusNow;
		if (busWrite && wb_adr_i == `CCS_ADDR_FLAGS)
			next_state.flags = state.flags
				& (wdata[7:0] | ~wmask[7:0]);
		if (state.curMode != `CCS_MODE_LISTEN_ALL)
		begin
			if (|(statusNow & ~state.statusPrev))
				next_state.flags[`CCS_F_ERROR] = 1'b1;
			if (invalidMsgEvt)
				next_state.flags[`CCS_F_INVALID] = 1'b1;
		end
		if (wakeEvt)
			next_state.flags[`CCS_F_WAKE] = 1'b1;
		if (fifoAlmostFullEvt)
			next_state.flags[`CCS_F_FIFO] = 1'b1;
		if (rxOverflowEvt)
			next_state.flags[`CCS_F_OVERFLOW] = 1'b1;
		if (rxBufferEvt)
			next_state.flags[`CCS_F_RXBUF] = 1'b1;
		if (txBufferEvt)
			next_state.flags[`CCS_F_TXBUF] = 1'b1;
		next_state.flags = next_state.flags & `CCS_FLAG_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state         <= '0;
			state.reqMode <= `CCS_MODE_CONFIG;
			state.curMode <= `CCS_MODE_CONFIG;
		end
		else
			state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Pins driven only in normal and configuration modes
	always_comb
	begin
		case (state.curMode)
			`CCS_MODE_NORMAL:   txDriven = 1'b1;
			`CCS_MODE_CONFIG:   txDriven = 1'b1;
			`CCS_MODE_LOOPBACK: txDriven = 1'b0;
			default:            txDriven = 1'b0;
		endcase
	end

	assign canTxPin     = txDriven ? coreTx : 1'b1;
	assign canTxOe_n    = !txDriven;
	assign pinsReleased = state.curMode == `CCS_MODE_LOOPBACK
		|| state.curMode == `CCS_MODE_DISABLE;
	assign coreRx = (state.curMode == `CCS_MODE_LOOPBACK)
		? coreTx : rxSync;

	assign listenAll       = state.curMode == `CCS_MODE_LISTEN_ALL;
	assign asmCopy         = state.asmCopy;
	assign abortAllTx      = state.abortAll;
	assign rxCapture       = state.capture;
	assign mapWindowSelect = state.mapWin;
	assign dataCompareBits = state.dnCount;
	assign currentMode     = state.curMode;
	assign dmaBufferTotal  = dmaCount(state.dma_buffer_count);
	assign moduleHalt      = state.idleStop && chipIdle;

	assign wb_dat_o = state.datOut;
	assign wb_ack_o = state.ack;
endmodule
`default_nettype wire

// >>> ccs_sva.sv
// Port checks for the CAN control block
`timescale 1ns/1ps
`default_nettype none
module ccs_sva
(
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       coreTx,
	input wire logic       coreRx,
	input wire logic       canTxOe_n,
	input wire logic       pinsReleased,
	input wire logic       protoError,
	input wire logic       rxMsgDone,
	input wire logic       listenAll,
	input wire logic       asmCopy,
	input wire logic       rxCapture,
	input wire logic [4:0] dataCompareIn,
	input wire logic [4:0] dataCompareBits,
	input wire logic [2:0] currentMode,
	input wire logic [5:0] dmaBufferTotal,
	input wire logic       chipIdle,
	input wire logic       moduleHalt,
	input wire logic       abortAllTx,
	input wire logic       allTxAborted
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("Bus request not answered");
	listen_all_a: assert property (listenAll == (currentMode == 3'h7))
		else $error("Listen-all flag wrong");
	asm_copy_a: assert property (protoError && listenAll |=> asmCopy)
		else $error("No assembly copy on error");
	loop_rx_a: assert property (currentMode == 3'h2 |-> coreRx == coreTx)
		else $error("Loopback receive wrong");
	pins_free_a: assert property (currentMode inside {3'h1, 3'h2}
		|-> pinsReleased && canTxOe_n) else $error("Pins not released");
	idle_halt_a: assert property (!chipIdle |-> !moduleHalt)
		else $error("Halt outside idle");
	abort_clear_a: assert property (abortAllTx && allTxAborted && !wb_cyc_i
		|=> !abortAllTx) else $error("Abort not cleared");
	mode_legal_a: assert property (!(currentMode inside {3'h5, 3'h6}))
		else $error("Reserved mode in force");
	capture_cause_a: assert property (rxCapture |-> $past(rxMsgDone))
		else $error("Capture without reception");
	compare_cnt_a: assert property (dataCompareBits ==
		($past(dataCompareIn) > 5'h11 ? 5'h00 : $past(dataCompareIn)))
		else $error("Compare count wrong");
	dma_count_a: assert property (dmaBufferTotal inside
		{6'h04, 6'h06, 6'h08, 6'h0C, 6'h10, 6'h18, 6'h20})
		else $error("Buffer total wrong");
endmodule
`default_nettype wire

// >>> ccs_bus_node.sv
// Other CAN nodes: free bit ticks and bus level
`timescale 1ns/1ps
`default_nettype none
module ccs_bus_node
#(
	parameter int BIT_CYC = 4
)
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic busy,
	output logic      bitTick,
	output logic      canRxPin
);
	int   cnt;
	logic phase;
	// A busy bus alternates levels so it never reads as idle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			bitTick <= 1'b0;
			phase <= 1'b0;
			canRxPin <= 1'b1;
		end
		else
		begin
			bitTick <= (cnt == BIT_CYC - 1);
			cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
			if (cnt == 0)
			begin
				phase <= ~phase;
				canRxPin <= busy ? phase : 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> can_mode_fifo_status_control_test.sv
// Self-checking bench for the CAN control block
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"
module can_mode_fifo_status_control_test;
	logic        clk_sys = 1'b0;
	logic        rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic        canRxPin, canTxPin, canTxOe_n, pinsReleased, busy;
	logic        bitTick, coreTx, coreRx, protoError, rxMsgDone;
	logic        allTxAborted, listenAll, asmCopy, abortAllTx, rxCapture;
	logic        mapWindowSelect, chipIdle, moduleHalt;
	logic        txBusOff, txPassive, rxPassive, txWarning, rxWarning;
	logic        invalidMsgEvt, wakeEvt, fifoAlmostFullEvt, rxOverflowEvt;
	logic        rxBufferEvt, txBufferEvt, fifoWrite, fifoRead;
	logic [3:0]  rxFilterHit;
	logic [4:0]  dataCompareIn, dataCompareBits;
	logic [2:0]  currentMode;
	logic [5:0]  dmaBufferTotal;
	logic [15:0] bufferPending, rd;
	logic [9:0]  ev;
	int          n_fail, checks_done;
	localparam logic [15:0] CLRV [5] = '{16'hDF, 16'hCB, 16'h8B, 16'h83, 0};
	localparam logic [15:0] CODEV [5] = '{16'h43, 16'h42, 16'h44, 16'h0A, 16'h40};
	localparam logic [5:0] DMAV [7] = '{4, 6, 8, 12, 16, 24, 32};
	localparam logic [2:0] REQV [6] = '{0, 1, 2, 3, 5, 7};
	localparam logic [2:0] CURV [6] = '{0, 1, 2, 3, 3, 7};
	localparam logic OEV [6] = '{0, 1, 1, 1, 1, 1};
	localparam logic RELV [6] = '{0, 1, 1, 0, 0, 0};
	assign {fifoRead, fifoWrite, rxMsgDone, invalidMsgEvt, wakeEvt, protoError,
		fifoAlmostFullEvt, rxOverflowEvt, rxBufferEvt, txBufferEvt} = ev;
	ccs_top #(.IDLE_BITS(3)) uut (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
		.canRxPin, .canTxPin, .canTxOe_n, .pinsReleased, .bitTick, .coreTx,
		.coreRx, .protoError, .rxMsgDone, .rxFilterHit, .allTxAborted,
		.dataCompareIn, .listenAll, .asmCopy, .abortAllTx, .rxCapture,
		.mapWindowSelect, .dataCompareBits, .currentMode, .dmaBufferTotal,
		.chipIdle, .moduleHalt, .txBusOff, .txPassive, .rxPassive, .txWarning,
		.rxWarning, .invalidMsgEvt, .wakeEvt, .fifoAlmostFullEvt,
		.rxOverflowEvt, .rxBufferEvt, .txBufferEvt, .bufferPending,
		.fifoWrite, .fifoRead);
	ccs_bus_node node (.clk_sys, .rst_n, .busy, .bitTick, .canRxPin);
	always #25 clk_sys = ~clk_sys;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [15:0] d);
		int w;
		w = 0;
		@(posedge clk_sys);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {16'h0000, d};
		// Wait for the answer; only the watchdog ends a hang
		while (wb_ack_o !== 1'b1)
		begin
			@(posedge clk_sys);
			w++;
		end
		// Taken one edge after raising, answered at the next
		chk(w, 32'h2);
		rd = wb_dat_o[15:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		xfer(1'b0, a, 16'h0000);
		chk(rd, exp);
	endtask
	task automatic pulse(input logic [9:0] m);
		@(posedge clk_sys);
		ev <= m;
		@(posedge clk_sys);
		ev <= 10'h000;
	endtask
	task automatic set_mode(input logic [2:0] m);
		wr(`CCS_ADDR_MODE, {5'h00, m, 8'h00});
		repeat (400) if (currentMode !== m) @(posedge clk_sys);
		@(posedge clk_sys);
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		final_report();
	end
	initial
	begin
		{rst_n, wb_cyc_i, wb_stb_i, wb_we_i, coreTx, busy} = 6'h00;
		{allTxAborted, chipIdle, txBusOff, txPassive, rxPassive} = 0;
		{txWarning, rxWarning, ev, rxFilterHit, dataCompareIn} = 0;
		{wb_adr_i, wb_dat_i, bufferPending, n_fail, checks_done} = 0;
		wb_sel_i = 4'h3;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdc(`CCS_ADDR_MODE, 16'h0480);
		rdc(`CCS_ADDR_VECTOR, 16'h0040);
		rdc(`CCS_ADDR_FLAGS, 16'h0000);
		// Raise every flag event and two status sources
		bufferPending <= 16'h0400;
		txWarning <= 1'b1;
		rxPassive <= 1'b1;
		pulse(10'h06F);
		rdc(`CCS_ADDR_FLAGS, 16'h0DEF);
		rdc(`CCS_ADDR_VECTOR, 16'h0041);
		wr(`CCS_ADDR_FLAGS, 16'hFFFF);
		rdc(`CCS_ADDR_FLAGS, 16'h0DEF);
		for (int i = 0; i < 5; i++)
		begin
			wr(`CCS_ADDR_FLAGS, CLRV[i]);
			rdc(`CCS_ADDR_VECTOR, CODEV[i]);
		end
		// FIFO pointers and wrap
		wr(`CCS_ADDR_FIFOCFG, 16'h0000);
		repeat (3) pulse(10'h100);
		rdc(`CCS_ADDR_FIFOPTR, 16'h0300);
		pulse(10'h100);
		pulse(10'h200);
		rdc(`CCS_ADDR_FIFOPTR, 16'h0001);
		for (int i = 0; i < 7; i++)
		begin
			wr(`CCS_ADDR_FIFOCFG, {i[2:0], 13'h0000});
			@(posedge clk_sys);
			chk(dmaBufferTotal, DMAV[i]);
		end
		wr(`CCS_ADDR_FIFOCFG, 16'hE01F);
		rdc(`CCS_ADDR_FIFOCFG, 16'hC01F);
		rdc(`CCS_ADDR_FIFOPTR, 16'h1F1F);
		dataCompareIn <= 5'h11;
		rdc(`CCS_ADDR_DCOUNT, 16'h0011);
		dataCompareIn <= 5'h12;
		rdc(`CCS_ADDR_DCOUNT, 16'h0000);
		// Idle stop, capture, window, abort
		chipIdle <= 1'b1;
		wr(`CCS_ADDR_MODE, 16'h2409);
		@(posedge clk_sys);
		chk(moduleHalt, 1'b1);
		chk(mapWindowSelect, 1'b1);
		rxFilterHit <= 4'h9;
		pulse(10'h080);
		@(posedge clk_sys);
		chk(rxCapture, 1'b1);
		rdc(`CCS_ADDR_VECTOR, 16'h0940);
		wr(`CCS_ADDR_MODE, 16'h3409);
		rdc(`CCS_ADDR_MODE, 16'h3489);
		chk(abortAllTx, 1'b1);
		allTxAborted <= 1'b1;
		repeat (2) @(posedge clk_sys);
		allTxAborted <= 1'b0;
		rdc(`CCS_ADDR_MODE, 16'h2489);
		chipIdle <= 1'b0;
		@(posedge clk_sys);
		@(posedge clk_sys);
		chk(moduleHalt, 1'b0);
		// Mode change held off while the bus is busy; let it go busy first
		busy <= 1'b1;
		chipIdle <= 1'b1;
		repeat (16) @(posedge clk_sys);
		wr(`CCS_ADDR_MODE, 16'h0000);
		repeat (60) @(posedge clk_sys);
		chk(currentMode, 3'h4);
		chk(moduleHalt, 1'b0);
		busy <= 1'b0;
		chipIdle <= 1'b0;
		for (int i = 0; i < 6; i++)
		begin
			set_mode(REQV[i]);
			chk(currentMode, CURV[i]);
			rdc(`CCS_ADDR_MODE, {5'h00, CURV[i], CURV[i], 5'h00});
			chk(canTxOe_n, OEV[i]);
			chk(pinsReleased, RELV[i]);
			chk(listenAll, CURV[i] == 3'h7);
			chk(canTxPin, OEV[i] ? 1'b1 : coreTx);
			if (CURV[i] == 3'h2)
				chk(coreRx, coreTx);
			repeat (4) @(posedge clk_sys) coreTx <= ~coreTx;
			pulse(10'h010);
		end
		// Listen-all: error and invalid flags stay clear, wake still sets
		txBusOff <= 1'b1;
		pulse(10'h060);
		rdc(`CCS_ADDR_FLAGS, 16'h2D40);
		rdc(`CCS_ADDR_VECTOR, 16'h0942);
		final_report();
	end
endmodule
bind ccs_top ccs_sva chk (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .coreTx, .coreRx, .canTxOe_n, .pinsReleased, .protoError,
	.rxMsgDone, .listenAll, .asmCopy, .rxCapture, .dataCompareIn,
	.dataCompareBits, .currentMode, .dmaBufferTotal, .chipIdle,
	.moduleHalt, .abortAllTx, .allTxAborted);
`default_nettype wire
